/* include/fan_pwm_pkg.sv */
package fan_pwm_pkg;
  // core clock
  localparam int CLK_FREQ_MHZ = 100;
  // internal pwm clock synthesised by a phase accumulator
  localparam int PWM_CLK_KHZ = 6400;
  localparam int ACC_MOD_KHZ = CLK_FREQ_MHZ * 1000;
  localparam logic [16:0] ACC_STEP = 17'(PWM_CLK_KHZ);
  localparam logic [16:0] ACC_MOD = 17'(ACC_MOD_KHZ);
  localparam logic [16:0] ACC_RESET = 17'h00000;
  // pwm clock dividers per frequency mode
  localparam logic [9:0] DIV_25K = 10'h001;
  localparam logic [9:0] DIV_1500 = 10'(17);
  localparam logic [9:0] DIV_150 = 10'(167);
  localparam logic [9:0] DIV_33 = 10'(758);
  // drive frequency codes
  localparam logic [1:0] DRV_33HZ = 2'h0;
  localparam logic [1:0] DRV_150HZ = 2'h1;
  localparam logic [1:0] DRV_1500HZ = 2'h2;
  localparam logic [1:0] DRV_25KHZ = 2'h3;
  // ramp rate codes {high, low}
  localparam logic [1:0] RAMP_SLOW = 2'h0;
  localparam logic [1:0] RAMP_SLOW_MED = 2'h1;
  localparam logic [1:0] RAMP_MED_FAST = 2'h2;
  localparam logic [1:0] RAMP_IMMEDIATE = 2'h3;
  // one code step per interval: 3.125 %/s is 8 codes/s
  localparam int RAMP_SLOW_STEP_US = 125000;
  localparam int RAMP_SLOW_MED_STEP_US = 62500;
  localparam int RAMP_MED_FAST_STEP_US = 31250;
  localparam int RAMP_SLOW_CYC = RAMP_SLOW_STEP_US * CLK_FREQ_MHZ;
  localparam int RAMP_SLOW_MED_CYC = RAMP_SLOW_MED_STEP_US * CLK_FREQ_MHZ;
  localparam int RAMP_MED_FAST_CYC = RAMP_MED_FAST_STEP_US * CLK_FREQ_MHZ;
  // spin-up timeout
  localparam int SPINUP_TIME_MS = 2000;
  localparam int SPINUP_CYC = SPINUP_TIME_MS * 1000 * CLK_FREQ_MHZ;
  localparam logic [1:0] SPIN_TACH_PULSES = 2'h2;
  // register map
  localparam logic [7:0] ADDR_LUT_FIRST = 8'h20;
  localparam logic [7:0] ADDR_LUT_LAST = 8'h4f;
  localparam logic [7:0] ADDR_DIRECT_DUTY = 8'h50;
  localparam logic [7:0] ADDR_CURRENT_DUTY = 8'h51;
  localparam int LUT_ENTRIES = 48;
  localparam logic [7:0] LUT_RESET = 8'hff;
  localparam logic [7:0] DIRECT_RESET = 8'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;
  // lookup windows in degrees C
  localparam logic signed [9:0] LUT_LOW_EDGE_C = 10'sd18;
  localparam logic signed [9:0] LUT_HIGH_EDGE_C = 10'sd110;
  localparam logic [5:0] LUT_TOP_INDEX = 6'h2f;
  localparam logic signed [9:0] LUT_HYSTERESIS_SELECT_SMALL_C = 10'sd2;
  localparam logic signed [9:0] LUT_HYSTERESIS_SELECT_LARGE_C = 10'sd4;
  // duty codes
  localparam logic [7:0] DUTY_ZERO = 8'h00;
  localparam logic [7:0] DUTY_FULL = 8'hff;

  typedef enum logic {SPIN_IDLE = 1'b0, SPIN_ACTIVE = 1'b1} spin_state_t;
endpackage : fan_pwm_pkg

/* design/fan_pwm_duty_engine.sv */
`timescale 1ns/1ps
module fan_pwm_duty_engine
  import fan_pwm_pkg::*;
#(
  parameter int unsigned RAMP_SLOW_CYCLES = RAMP_SLOW_CYC,
  parameter int unsigned RAMP_SLOW_MED_CYCLES = RAMP_SLOW_MED_CYC,
  parameter int unsigned RAMP_MED_FAST_CYCLES = RAMP_MED_FAST_CYC,
  parameter int unsigned SPINUP_CYCLES = SPINUP_CYC
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WE,
  output logic [7:0] REG_RDATA,
  input wire logic signed [7:0] LOCAL_TEMP,
  input wire logic signed [7:0] REMOTE_TEMP,
  input wire logic INDEX_SOURCE_SELECT,
  input wire logic MAX_TEMP_INDEX_SELECT,
  input wire logic LUT_HYSTERESIS_SELECT,
  input wire logic DIRECT_CONTROL_ENABLE,
  input wire logic RAMP_RATE_BIT_LOW,
  input wire logic RAMP_RATE_BIT_HIGH,
  input wire logic SPINUP_ENABLE,
  input wire logic [1:0] DRIVE_FREQUENCY_SELECT,
  input wire logic PULSE_STRETCH_ENABLE,
  input wire logic FULL_DUTY_TACH_ONLY,
  input wire logic OUTPUT_POLARITY_SELECT,
  input wire logic STRETCH_REQUEST,
  input wire logic TACH1_IN,
  input wire logic TACH2_IN,
  input wire logic TACH1_ENABLE,
  input wire logic TACH2_ENABLE,
  output logic PWM_OUT,
  output logic TACH_VALID,
  output logic SPINUP_ACTIVE
);

  ////////////////////////////////////////////////////////////////////////////
  // temperature to lookup index
  function automatic logic [5:0] temp_to_index(input logic signed [9:0] t);
    logic signed [9:0] off;
    off = t - LUT_LOW_EDGE_C;
    if (t < LUT_LOW_EDGE_C) begin
      temp_to_index = 6'h00;
    end else if (t >= LUT_HIGH_EDGE_C) begin
      temp_to_index = LUT_TOP_INDEX;
    end else begin
      temp_to_index = 6'(off[9:1]) + 6'h01;
    end
  endfunction : temp_to_index

  logic [7:0] lut_r [LUT_ENTRIES];
  logic [7:0] direct_r, direct_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [7:0] cur_r, cur_nxt;
  logic [5:0] idx_r, idx_nxt;
  logic signed [9:0] temp_sel, lut_hysteresis_select;
  logic [5:0] raw_idx, down_idx;
  logic [7:0] lut_off;
  logic lut_hit;

  ////////////////////////////////////////////////////////////////////////////
  // register port decode and read mux
  always_comb begin
    lut_off = REG_ADDR - ADDR_LUT_FIRST;
    lut_hit = (REG_ADDR >= ADDR_LUT_FIRST) && (REG_ADDR <= ADDR_LUT_LAST);
    direct_nxt = direct_r;
    if (REG_WE && REG_ADDR == ADDR_DIRECT_DUTY) begin
      direct_nxt = REG_WDATA;
    end
    rdata_nxt = RDATA_RESET; // unmapped reads return zero
    if (lut_hit) begin
      rdata_nxt = lut_r[lut_off[5:0]];
    end else if (REG_ADDR == ADDR_DIRECT_DUTY) begin
      rdata_nxt = direct_r;
    end else if (REG_ADDR == ADDR_CURRENT_DUTY) begin
      rdata_nxt = cur_r;
    end
  end

  // lookup memory is written in place rather than through a next-value copy
  always_ff @(posedge MCLK) begin
    if (RST) begin
      for (int i = 0; i < LUT_ENTRIES; i++) begin
        lut_r[i] <= LUT_RESET;
      end
    end else if (REG_WE && lut_hit) begin
      lut_r[lut_off[5:0]] <= REG_WDATA;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      direct_r <= DIRECT_RESET;
      rdata_r <= RDATA_RESET;
    end else begin
      direct_r <= direct_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  assign REG_RDATA = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // index source and hysteresis: rise at once, fall only past the margin
  always_comb begin
    if (MAX_TEMP_INDEX_SELECT) begin
      temp_sel = (LOCAL_TEMP > REMOTE_TEMP) ? 10'(LOCAL_TEMP) : 10'(REMOTE_TEMP);
    end else if (INDEX_SOURCE_SELECT) begin
      temp_sel = 10'(REMOTE_TEMP);
    end else begin
      temp_sel = 10'(LOCAL_TEMP);
    end
    lut_hysteresis_select = LUT_HYSTERESIS_SELECT ? LUT_HYSTERESIS_SELECT_LARGE_C : LUT_HYSTERESIS_SELECT_SMALL_C;
    raw_idx = temp_to_index(temp_sel);
    down_idx = temp_to_index(temp_sel + lut_hysteresis_select);
    idx_nxt = idx_r;
    if (raw_idx > idx_r) begin
      idx_nxt = raw_idx;
    end else if (down_idx < idx_r) begin
      idx_nxt = down_idx;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      idx_r <= 6'h00;
    end else begin
      idx_r <= idx_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // target select, spin-up and ramp
  spin_state_t spin_r, spin_nxt;
  logic [7:0] sel_target, prev_target_r, prev_target_nxt;
  logic [27:0] spin_cnt_r, spin_cnt_nxt;
  logic [23:0] ramp_cnt_r, ramp_cnt_nxt, ramp_last;
  logic [1:0] t1_cnt_r, t1_cnt_nxt, t2_cnt_r, t2_cnt_nxt;
  logic [1:0] ramp_code;
  logic spin_start, spin_done, tach_done;
  logic [2:0] t1_sync_r, t2_sync_r;
  logic t1_edge, t2_edge;

  // two flops per tach pin, third flop only for the edge detector
  always_ff @(posedge MCLK) begin
    if (RST) begin
      t1_sync_r <= 3'h7; // tach lines idle high on their pull-ups: no false edge
      t2_sync_r <= 3'h7;
    end else begin
      t1_sync_r <= {t1_sync_r[1:0], TACH1_IN};
      t2_sync_r <= {t2_sync_r[1:0], TACH2_IN};
    end
  end
  assign t1_edge = t1_sync_r[1] && !t1_sync_r[2];
  assign t2_edge = t2_sync_r[1] && !t2_sync_r[2];

  always_comb begin
    sel_target = DIRECT_CONTROL_ENABLE ? direct_r : lut_r[idx_r];
    ramp_code = {RAMP_RATE_BIT_HIGH, RAMP_RATE_BIT_LOW};
    case (ramp_code)
      RAMP_SLOW: ramp_last = 24'(RAMP_SLOW_CYCLES - 1);
      RAMP_SLOW_MED: ramp_last = 24'(RAMP_SLOW_MED_CYCLES - 1);
      RAMP_MED_FAST: ramp_last = 24'(RAMP_MED_FAST_CYCLES - 1);
      default: ramp_last = 24'h000000;
    endcase
    spin_start = SPINUP_ENABLE && prev_target_r == DUTY_ZERO
                 && sel_target != DUTY_ZERO;
    tach_done = (TACH1_ENABLE || TACH2_ENABLE)
                && (!TACH1_ENABLE || t1_cnt_r == SPIN_TACH_PULSES)
                && (!TACH2_ENABLE || t2_cnt_r == SPIN_TACH_PULSES);
    spin_done = !SPINUP_ENABLE || tach_done
                || spin_cnt_r == 28'(SPINUP_CYCLES - 1);
    prev_target_nxt = sel_target;
    spin_nxt = spin_r;
    spin_cnt_nxt = 28'h0000000;
    t1_cnt_nxt = 2'h0;
    t2_cnt_nxt = 2'h0;
    ramp_cnt_nxt = 24'h000000;
    cur_nxt = cur_r;
    case (spin_r)
      SPIN_IDLE: begin
        if (spin_start) begin
          spin_nxt = SPIN_ACTIVE;
          cur_nxt = DUTY_FULL;
        end else if (ramp_code == RAMP_IMMEDIATE) begin
          cur_nxt = sel_target;
        end else if (ramp_cnt_r >= ramp_last) begin
          // step toward whatever the target is right now
          if (cur_r < sel_target) begin
            cur_nxt = cur_r + 8'h01;
          end else if (cur_r > sel_target) begin
            cur_nxt = cur_r - 8'h01;
          end
        end else begin
          ramp_cnt_nxt = ramp_cnt_r + 24'h000001;
        end
      end
      SPIN_ACTIVE: begin
        cur_nxt = DUTY_FULL;
        spin_cnt_nxt = spin_cnt_r + 28'h0000001;
        t1_cnt_nxt = (t1_edge && t1_cnt_r != SPIN_TACH_PULSES) ? t1_cnt_r + 2'h1 : t1_cnt_r;
        t2_cnt_nxt = (t2_edge && t2_cnt_r != SPIN_TACH_PULSES) ? t2_cnt_r + 2'h1 : t2_cnt_r;
        if (spin_done) begin
          spin_nxt = SPIN_IDLE;
          cur_nxt = sel_target;
          spin_cnt_nxt = 28'h0000000;
        end
      end
      default: spin_nxt = SPIN_IDLE;
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      spin_r <= SPIN_IDLE;
      spin_cnt_r <= 28'h0000000;
      t1_cnt_r <= 2'h0;
      t2_cnt_r <= 2'h0;
      ramp_cnt_r <= 24'h000000;
      cur_r <= DUTY_ZERO;
      prev_target_r <= DUTY_ZERO;
    end else begin
      spin_r <= spin_nxt;
      spin_cnt_r <= spin_cnt_nxt;
      t1_cnt_r <= t1_cnt_nxt;
      t2_cnt_r <= t2_cnt_nxt;
      ramp_cnt_r <= ramp_cnt_nxt;
      cur_r <= cur_nxt;
      prev_target_r <= prev_target_nxt;
    end
  end
  assign SPINUP_ACTIVE = (spin_r == SPIN_ACTIVE);

  ////////////////////////////////////////////////////////////////////////////
  // pwm timebase: the accumulator averages 6.4 MHz since 100/6.4 is not whole
  logic [16:0] acc_r, acc_nxt, acc_sum;
  logic [9:0] div_cnt_r, div_cnt_nxt, divisor;
  logic [7:0] period_cnt_r, period_cnt_nxt, period_duty_r, period_duty_nxt;
  logic tick, pclk_tick, stretch_on, active, pwm_r, pwm_nxt, valid_r, valid_nxt;

  always_comb begin
    acc_sum = acc_r + ACC_STEP;
    tick = acc_sum >= ACC_MOD;
    acc_nxt = tick ? acc_sum - ACC_MOD : acc_sum;
    case (DRIVE_FREQUENCY_SELECT)
      DRV_25KHZ: divisor = DIV_25K;
      DRV_1500HZ: divisor = DIV_1500;
      DRV_150HZ: divisor = DIV_150;
      default: divisor = DIV_33;
    endcase
    pclk_tick = tick && div_cnt_r >= divisor - 10'h001;
    div_cnt_nxt = div_cnt_r;
    // a mode change can leave the count past the new divisor: restart it at once
    if (div_cnt_r >= divisor) begin
      div_cnt_nxt = 10'h000;
    end else if (pclk_tick) begin
      div_cnt_nxt = 10'h000;
    end else if (tick) begin
      div_cnt_nxt = div_cnt_r + 10'h001;
    end
    period_cnt_nxt = pclk_tick ? period_cnt_r + 8'h01 : period_cnt_r;
    // duty is taken only at the period boundary so no runt pulses appear
    period_duty_nxt = period_duty_r;
    if (pclk_tick && period_cnt_r == DUTY_FULL) begin
      period_duty_nxt = cur_r;
    end
    stretch_on = DRIVE_FREQUENCY_SELECT == DRV_33HZ && PULSE_STRETCH_ENABLE
                 && !FULL_DUTY_TACH_ONLY && STRETCH_REQUEST;
    active = period_duty_r == DUTY_FULL || period_cnt_r < period_duty_r
             || stretch_on;
    pwm_nxt = active ^ OUTPUT_POLARITY_SELECT;
    if (DRIVE_FREQUENCY_SELECT != DRV_33HZ) begin
      valid_nxt = 1'b1;
    end else if (FULL_DUTY_TACH_ONLY) begin
      valid_nxt = cur_r == DUTY_FULL;
    end else if (PULSE_STRETCH_ENABLE) begin
      valid_nxt = stretch_on;
    end else begin
      valid_nxt = 1'b1;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      acc_r <= ACC_RESET;
      div_cnt_r <= 10'h000;
      period_cnt_r <= 8'h00;
      period_duty_r <= DUTY_ZERO;
      pwm_r <= 1'b0;
      valid_r <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      div_cnt_r <= div_cnt_nxt;
      period_cnt_r <= period_cnt_nxt;
      period_duty_r <= period_duty_nxt;
      pwm_r <= pwm_nxt;
      valid_r <= valid_nxt;
    end
  end
  assign PWM_OUT = pwm_r;
  assign TACH_VALID = valid_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  sequence spin_enter;
    spin_r == SPIN_IDLE && spin_start;
  endsequence

  a_spin_full: assert property (spin_enter |=> spin_r == SPIN_ACTIVE && cur_r == DUTY_FULL)
    else $error("spin-up did not force full duty");
  a_spin_bound: assert property (spin_cnt_r < 28'(SPINUP_CYCLES))
    else $error("spin-up outlived its timeout");
  a_spin_gate: assert property (!SPINUP_ENABLE && spin_r == SPIN_IDLE |=> spin_r == SPIN_IDLE)
    else $error("spin-up started while disabled");
  a_full_high: assert property (period_duty_r == DUTY_FULL && !OUTPUT_POLARITY_SELECT
    |=> PWM_OUT)
    else $error("full duty output not high");
  a_full_low: assert property (period_duty_r == DUTY_FULL && OUTPUT_POLARITY_SELECT
    |=> !PWM_OUT)
    else $error("inverted full duty output not low");
  a_zero_off: assert property (period_duty_r == DUTY_ZERO && !stretch_on
    && !OUTPUT_POLARITY_SELECT |=> !PWM_OUT)
    else $error("zero duty output active");
  a_div_range: assert property (div_cnt_r < divisor || $changed(DRIVE_FREQUENCY_SELECT))
    else $error("pwm divider out of range");
  a_fast_tick: assert property (DRIVE_FREQUENCY_SELECT == DRV_25KHZ && tick |-> pclk_tick)
    else $error("25kHz mode skipped a pwm tick");
  a_ramp_step: assert property (spin_r == SPIN_IDLE && !spin_start
    && ramp_code != RAMP_IMMEDIATE |=> cur_r == $past(cur_r)
    || cur_r == $past(cur_r) + 8'h01 || cur_r == $past(cur_r) - 8'h01)
    else $error("ramp moved more than one code");
  a_direct_track: assert property (DIRECT_CONTROL_ENABLE && ramp_code == RAMP_IMMEDIATE
    && spin_r == SPIN_IDLE && !spin_start |=> cur_r == $past(direct_r))
    else $error("direct target not applied");
  a_tach_full: assert property (DRIVE_FREQUENCY_SELECT == DRV_33HZ && FULL_DUTY_TACH_ONLY
    |=> TACH_VALID == ($past(cur_r) == DUTY_FULL))
    else $error("tach validity wrong in full-duty mode");
  a_index_rise: assert property (raw_idx > idx_r |=> idx_r == $past(raw_idx))
    else $error("lookup index did not follow rising temperature");

endmodule : fan_pwm_duty_engine

/* verification/fan_model.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// fan partner: turns while its drive is active and toggles its tach line
module fan_model #(
  parameter int TACH_HALF = 8
) (
  input wire logic clk,
  input wire logic pwm,
  input wire logic active_low,
  input wire logic stall,
  output logic tach
);
  int cnt;

  initial begin
    tach = 1'b1;
    cnt = 0;
  end

  // open-drain tach with pull-up: rests high when undriven or stalled, so a
  // stopped fan never shows an edge that could end spin-up early
  always @(posedge clk) begin
    if ((pwm != active_low) && !stall) begin
      cnt <= (cnt == TACH_HALF - 1) ? 0 : cnt + 1;
      if (cnt == TACH_HALF - 1) begin
        tach <= ~tach;
      end
    end else begin
      tach <= 1'b1;
      cnt <= 0;
    end
  end
endmodule : fan_model

/* verification/tb_fan_pwm_duty_engine.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module tb_fan_pwm_duty_engine;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v;
  logic we = 1'b0, isel = 1'b0, msel = 1'b0, hsel = 1'b0, dfc = 1'b1;
  logic rlo = 1'b1, rhi = 1'b1, spinup_enable = 1'b0, pulse_stretch_enable = 1'b0, ftach = 1'b0, pol = 1'b0;
  logic t1e = 1'b1, t2e = 1'b1, stall = 1'b0, str = 1'b0;
  logic [1:0] drv = 2'h3;
  logic signed [7:0] lt = 8'sh00, rt = 8'sh00;
  logic pwm, tvalid, spin, tach;
  int n_mismatch = 0;
  int comparisons = 0;

  // short counts keep ramp and spin-up runs brief
  fan_pwm_duty_engine #(.RAMP_SLOW_CYCLES(40), .RAMP_SLOW_MED_CYCLES(20),
    .RAMP_MED_FAST_CYCLES(10), .SPINUP_CYCLES(10000)) u_dut (
    .MCLK(clk), .RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WE(we),
    .REG_RDATA(rdata), .LOCAL_TEMP(lt), .REMOTE_TEMP(rt), .INDEX_SOURCE_SELECT(isel),
    .MAX_TEMP_INDEX_SELECT(msel), .LUT_HYSTERESIS_SELECT(hsel),
    .DIRECT_CONTROL_ENABLE(dfc), .RAMP_RATE_BIT_LOW(rlo), .RAMP_RATE_BIT_HIGH(rhi),
    .SPINUP_ENABLE(spinup_enable), .DRIVE_FREQUENCY_SELECT(drv), .PULSE_STRETCH_ENABLE(pulse_stretch_enable),
    .FULL_DUTY_TACH_ONLY(ftach), .OUTPUT_POLARITY_SELECT(pol), .STRETCH_REQUEST(str),
    .TACH1_IN(tach), .TACH2_IN(tach), .TACH1_ENABLE(t1e), .TACH2_ENABLE(t2e),
    .PWM_OUT(pwm), .TACH_VALID(tvalid), .SPINUP_ACTIVE(spin));

  fan_model u_fan (.clk(clk), .pwm(pwm), .active_low(pol), .stall(stall), .tach(tach));

  always #5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  // bus cycles and compares
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask : wr

  // read data is registered: valid one edge after the address is taken
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    step(2);
    d = rdata;
  endtask : rd

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: value %h, want %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: flag %b, want %b", $time, got, exp);
    end
  endtask : chk1

  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    rd(8'h51, v); chk8(v, 8'h00);
    rd(8'h50, v); chk8(v, 8'h00);
    rd(8'h20, v); chk8(v, 8'hff);
    rd(8'h4f, v); chk8(v, 8'hff);
    wr(8'h51, 8'h5a);
    rd(8'h51, v); chk8(v, 8'h00);
    rd(8'h60, v); chk8(v, 8'h00);
    chk1(spin, 1'b0);
  endtask : t_reset

  task automatic t_ramp();
    int iv[3] = '{40, 20, 10};
    logic [7:0] tgt;
    wr(8'h50, 8'h80);
    step(3);
    rd(8'h51, v); chk8(v, 8'h80);
    for (int c = 0; c < 3; c++) begin
      @(posedge clk);
      {rhi, rlo} <= 2'(c);
      tgt = 8'(8'h80 + 4 * (c + 1));
      wr(8'h50, tgt);
      rd(8'h51, v); chk1(v === tgt, 1'b0);
      step(5 * (iv[c] + 1));
      rd(8'h51, v); chk8(v, tgt);
    end
    // retarget mid-ramp: must turn round, not finish the old climb
    @(posedge clk);
    {rhi, rlo} <= 2'h0;
    wr(8'h50, 8'ha0);
    step(82);
    wr(8'h50, 8'h80);
    step(700);
    rd(8'h51, v); chk8(v, 8'h80);
    @(posedge clk);
    {rhi, rlo} <= 2'h3;
  endtask : t_ramp

  function automatic int idx(input int t);
    return (t < 18) ? 0 : (t >= 110) ? 47 : (t - 18) / 2 + 1;
  endfunction : idx

  task automatic t_lut();
    int tl[11] = '{25, 25, 25, 120, 10, 25, 22, 21, 25, 21, 19};
    int tr[11] = '{0, 40, 40, 40, -5, 0, 0, 0, 0, 0, 0};
    logic sm[11] = '{0, 1, 0, 0, 0, 0, 0, 0, 0, 0, 0};
    logic mx[11] = '{0, 0, 1, 1, 1, 0, 0, 0, 0, 0, 0};
    logic hy[11] = '{0, 0, 0, 0, 0, 0, 0, 0, 1, 1, 1};
    int ex[11];
    for (int i = 0; i < 48; i++) begin
      wr(8'(8'h20 + i), 8'(8'h10 + i));
    end
    // falling temperatures keep the old index until past the hysteresis band
    ex = '{4, idx(40), idx(40), 47, 0, 4, 4, idx(23), 4, 4, idx(23)};
    @(posedge clk);
    dfc <= 1'b0;
    for (int i = 0; i < 11; i++) begin
      @(posedge clk);
      lt <= 8'(tl[i]);
      rt <= 8'(tr[i]);
      isel <= sm[i];
      msel <= mx[i];
      hsel <= hy[i];
      step(4);
      rd(8'h51, v); chk8(v, 8'(ex[i] + 16));
    end
    @(posedge clk);
    dfc <= 1'b1;
  endtask : t_lut

  // bounded wait for a pwm level
  task automatic to_level(input logic l);
    int n;
    n = 0;
    while (pwm !== l && n < 5000) begin
      step(1);
      n++;
    end
  endtask : to_level

  task automatic t_pwm();
    logic [7:0] d[4] = '{8'h00, 8'h40, 8'hff, 8'h40};
    logic p[4] = '{1'b0, 1'b0, 1'b0, 1'b1};
    int hi, expn;
    realtime t0;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      pol <= p[i];
      wr(8'h50, d[i]);
      step(4100);
      hi = 0;
      // one 25kHz period is exactly 4000 core cycles
      repeat (4000) begin
        step(1);
        if (pwm === ~p[i]) hi++;
      end
      expn = (d[i] == 8'hff) ? 4000 : d[i] * 4000 / 256;
      chk1(hi >= expn - 20 && hi <= expn + 20, 1'b1);
    end
    to_level(1'b0);
    to_level(1'b1);
    t0 = $realtime;
    to_level(1'b0);
    to_level(1'b1);
    chk1($realtime - t0 > 39800 && $realtime - t0 < 40200, 1'b1);
    @(posedge clk);
    pol <= 1'b0;
  endtask : t_pwm

  task automatic t_tach();
    chk1(tvalid, 1'b1);
    @(posedge clk);
    drv <= 2'h0;
    ftach <= 1'b1;
    wr(8'h50, 8'h40);
    step(4);
    chk1(tvalid, 1'b0);
    wr(8'h50, 8'hff);
    step(4);
    chk1(tvalid, 1'b1);
    // stretching mode: valid only while a stretched pulse is requested
    @(posedge clk);
    ftach <= 1'b0;
    pulse_stretch_enable <= 1'b1;
    str <= 1'b1;
    step(4);
    chk1(tvalid, 1'b1);
    @(posedge clk);
    str <= 1'b0;
    step(4);
    chk1(tvalid, 1'b0);
    @(posedge clk);
    drv <= 2'h3;
    pulse_stretch_enable <= 1'b0;
  endtask : t_tach

  // start from a zero target, then ask for 40h
  task automatic kick();
    wr(8'h50, 8'h00);
    step(4);
    wr(8'h50, 8'h40);
    step(3);
  endtask : kick

  task automatic t_spin();
    kick();
    chk1(spin, 1'b0);
    rd(8'h51, v); chk8(v, 8'h40);
    @(posedge clk);
    spinup_enable <= 1'b1;
    stall <= 1'b1;
    kick();
    chk1(spin, 1'b1);
    rd(8'h51, v); chk8(v, 8'hff);
    step(9000);
    chk1(spin, 1'b1);
    step(1200);
    chk1(spin, 1'b0);
    rd(8'h51, v); chk8(v, 8'h40);
    // a turning fan ends spin-up long before the timeout
    @(posedge clk);
    stall <= 1'b0;
    kick();
    chk1(spin, 1'b1);
    step(4300);
    chk1(spin, 1'b0);
    rd(8'h51, v); chk8(v, 8'h40);
  endtask : t_spin

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_ramp();
    t_lut();
    t_pwm();
    t_tach();
    t_spin();
    finish_test();
  end

  // the whole run needs about 0.6 ms
  initial begin
    #900000;
    n_mismatch++;
    $display("unexpected at %0t: watchdog expired", $time);
    finish_test();
  end
endmodule : tb_fan_pwm_duty_engine
